// ### src/aiaw_consts.svh
`ifndef AIAW_CONSTS_SVH
`define AIAW_CONSTS_SVH
// Notes on behaviour
// - No process alarms: integer, or 16ch single-ended float
// - Limits compared in scaled engineering units
// - Set alarm holds while input within deadband
// - Unlatched alarm clears when condition and deadband end
// - Four alarm points per channel, each own flag
// - Latched alarm stays set after condition clears
// - Rate is sample difference over sample period
// - Rate compared by magnitude, both directions
// - No rate alarm: integer, or 16ch single-ended float
// - Wire-off forces substitute data, sets fault flag
// - All alarms disabled holds range flags zero
// - Odd channel wire-off: minimum or -32767, below flag
// - Even channel wire-off: maximum or 32767, above flag
// - Other wiring wire-off: minimum or -32768, below flag
// - Another wiring wire-off: maximum or 32768, above flag
// - Current wiring reacts as differential voltage
// ==================================================
// Register offsets
`define AIAW_OFS_CTRL 12'h000
`define AIAW_OFS_RTS 12'h004
`define AIAW_OFS_LATCH 12'h008
`define AIAW_OFS_ALMDIS 12'h00c
`define AIAW_OFS_IRQST 12'h010
`define AIAW_OFS_IRQMSK 12'h014
`define AIAW_FLG_REGION 7'h02
`define AIAW_CFG_REGION 4'h1
// ==================================================
// Control fields
`define AIAW_CTRL_INT 0
`define AIAW_CTRL_V16 1
`define AIAW_CTRL_SE 2
`define AIAW_CTRL_APP 4:3
// Per channel config word index
`define AIAW_C_HH 3'h0
`define AIAW_C_H 3'h1
`define AIAW_C_L 3'h2
`define AIAW_C_LL 3'h3
`define AIAW_C_DB 3'h4
`define AIAW_C_RATE 3'h5
`define AIAW_C_RMIN 3'h6
`define AIAW_C_RMAX 3'h7
// Flag bits
`define AIAW_F_HH 0
`define AIAW_F_H 1
`define AIAW_F_L 2
`define AIAW_F_LL 3
`define AIAW_F_RATE 4
`define AIAW_F_BELOW 5
`define AIAW_F_ABOVE 6
`define AIAW_F_WOFF 7
// ==================================================
// Values
`define AIAW_NCH 8
`define AIAW_CTRL_RST 32'h0000_0000
`define AIAW_RTS_RST 16'h0064
`define AIAW_MS_PER_S 48'h0000_0000_03e8
`define AIAW_SUB_NEG1 32'hffff_8001
`define AIAW_SUB_POS1 32'h0000_7fff
`define AIAW_SUB_NEG0 32'hffff_8000
`define AIAW_SUB_POS0 32'h0000_8000
`endif

// ### src/aiaw_pkg.sv
`default_nettype none
package aiaw_pkg;
   typedef logic signed [31:0] aiaw_data_t;
   typedef logic [7:0] aiaw_flags_t;
   typedef enum logic [1:0] {
      AIAW_APP_DIFFV,
      AIAW_APP_CURR,
      AIAW_APP_UNDER,
      AIAW_APP_OVER
   } aiaw_app_t;
endpackage
`default_nettype wire

// ### src/aiaw_alarm.sv
`include "aiaw_consts.svh"
`default_nettype none
module aiaw_alarm (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic samp_valid,
   input wire logic [2:0] samp_chan,
   input wire logic [31:0] samp_data,
   input wire logic samp_wire_off,
   output logic out_valid,
   output logic [2:0] out_chan,
   output logic [31:0] out_data,
   output logic [7:0] out_flags,
   output logic irq
);
   // ==================================================
   // Storage
   logic [31:0] ctrl;
   logic [15:0] rts_ms;
   logic [7:0] latch_en;
   logic [7:0] alm_dis;
   logic [3:0] irq_st;
   logic [3:0] irq_mask;
   aiaw_pkg::aiaw_data_t cfg [0:7][0:7]; // Signed: compared with d
   aiaw_pkg::aiaw_flags_t flags [0:7];
   aiaw_pkg::aiaw_data_t prev [0:7];
   logic [7:0] prev_ok;

   // One alarm point: set on condition, hold by latch or deadband
   function automatic logic aiaw_point(input logic old, input logic clr,
         input logic latch, input logic hi, input aiaw_pkg::aiaw_data_t d,
         input aiaw_pkg::aiaw_data_t lim, input aiaw_pkg::aiaw_data_t db);
      logic cond;
      logic band;
      cond = hi ? (d > lim) : (d < lim);
      band = hi ? (d > lim - db) : (d < lim + db);
      return cond | (old & ~clr & (latch | band));
   endfunction

   // ==================================================
   // APB decode
   wire acc = psel & penable;
   wire wr_go = acc & pready & pwrite;
   wire in_cfg = paddr[11:8] == `AIAW_CFG_REGION;
   wire in_flg = paddr[11:5] == `AIAW_FLG_REGION;
   wire [2:0] a_idx = paddr[4:2];
   wire [2:0] a_ch = paddr[7:5];
   wire in_glb = paddr == `AIAW_OFS_CTRL || paddr == `AIAW_OFS_RTS ||
      paddr == `AIAW_OFS_LATCH || paddr == `AIAW_OFS_ALMDIS ||
      paddr == `AIAW_OFS_IRQST || paddr == `AIAW_OFS_IRQMSK;
   wire mapped = in_glb | ((in_cfg | in_flg) & paddr[1:0] == 2'h0);
   wire flg_clr = wr_go & in_flg & paddr[1:0] == 2'h0; // Misaligned ignored
   logic [31:0] rd_mux;

   // Read selection
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (in_cfg) begin
         rd_mux = cfg[a_ch][a_idx];
      end else if (in_flg) begin
         rd_mux = {24'h00_0000, flags[a_idx]};
      end else begin
         case (paddr)
            `AIAW_OFS_CTRL: rd_mux = ctrl;
            `AIAW_OFS_RTS: rd_mux = {16'h0000, rts_ms};
            `AIAW_OFS_LATCH: rd_mux = {24'h00_0000, latch_en};
            `AIAW_OFS_ALMDIS: rd_mux = {24'h00_0000, alm_dis};
            `AIAW_OFS_IRQST: rd_mux = {28'h000_0000, irq_st};
            `AIAW_OFS_IRQMSK: rd_mux = {28'h000_0000, irq_mask};
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   end

   // ==================================================
   // Sample evaluation
   wire [2:0] sc = samp_chan;
   wire ctl_int = ctrl[`AIAW_CTRL_INT];
   wire mode_off = ctl_int | (ctrl[`AIAW_CTRL_V16] & ctrl[`AIAW_CTRL_SE]);
   wire alm_en = ~mode_off & ~alm_dis[sc];
   wire rng_en = ~alm_dis[sc];
   wire [1:0] app = ctrl[`AIAW_CTRL_APP];
   wire app_diff = app == aiaw_pkg::AIAW_APP_DIFFV ||
      app == aiaw_pkg::AIAW_APP_CURR;
   wire sub_below = app_diff ? sc[0] : app == aiaw_pkg::AIAW_APP_UNDER;
   wire [31:0] int_sub = app_diff ?
      (sc[0] ? `AIAW_SUB_NEG1 : `AIAW_SUB_POS1) :
      (sub_below ? `AIAW_SUB_NEG0 : `AIAW_SUB_POS0);
   wire aiaw_pkg::aiaw_data_t rmin = cfg[sc][`AIAW_C_RMIN];
   wire aiaw_pkg::aiaw_data_t rmax = cfg[sc][`AIAW_C_RMAX];
   wire [31:0] sub_val = ctl_int ? int_sub : (sub_below ? rmin : rmax);
   wire aiaw_pkg::aiaw_data_t d = samp_wire_off ? sub_val : samp_data;
   wire below = rng_en &
      (samp_wire_off ? sub_below : d < rmin);
   wire above = rng_en &
      (samp_wire_off ? ~sub_below : d > rmax);
   wire clr_here = flg_clr & a_idx == sc;
   wire [7:0] clr_bits = clr_here ? pwdata[7:0] : 8'h00;
   wire aiaw_pkg::aiaw_flags_t old = flags[sc];
   wire lat = latch_en[sc];
   wire aiaw_pkg::aiaw_data_t db = cfg[sc][`AIAW_C_DB];
   // Limits are scaled units, same as d
   wire p_hh = alm_en & aiaw_point(old[`AIAW_F_HH], clr_bits[`AIAW_F_HH],
      lat, 1'b1, d, cfg[sc][`AIAW_C_HH], db);
   wire p_h = alm_en & aiaw_point(old[`AIAW_F_H], clr_bits[`AIAW_F_H],
      lat, 1'b1, d, cfg[sc][`AIAW_C_H], db);
   wire p_l = alm_en & aiaw_point(old[`AIAW_F_L], clr_bits[`AIAW_F_L],
      lat, 1'b0, d, cfg[sc][`AIAW_C_L], db);
   wire p_ll = alm_en & aiaw_point(old[`AIAW_F_LL], clr_bits[`AIAW_F_LL],
      lat, 1'b0, d, cfg[sc][`AIAW_C_LL], db);
   wire any_cond = alm_en & (d > cfg[sc][`AIAW_C_HH] |
      d > cfg[sc][`AIAW_C_H] | d < cfg[sc][`AIAW_C_L] |
      d < cfg[sc][`AIAW_C_LL]);
   // Rate: |diff| * 1000 > trigger * period_ms, avoids a divider
   wire aiaw_pkg::aiaw_data_t pv = prev[sc];
   wire signed [32:0] diff = {d[31], d} - {pv[31], pv};
   wire [32:0] mag = diff[32] ? 33'(-diff) : diff;
   wire [47:0] lhs = {15'h0000, mag} * `AIAW_MS_PER_S;
   wire [47:0] rhs = {16'h0000, cfg[sc][`AIAW_C_RATE]} * {32'h0, rts_ms};
   wire rate_f = alm_en & prev_ok[sc] & (lhs > rhs);
   wire [7:0] nf = {1'b1 & samp_wire_off, above, below, rate_f,
      p_ll, p_l, p_h, p_hh};
   wire [3:0] ev = samp_valid ?
      {below | above, samp_wire_off, rate_f, any_cond} : 4'h0;
   wire [3:0] irq_clr = (wr_go && paddr == `AIAW_OFS_IRQST) ?
      pwdata[3:0] : 4'h0;
   wire [3:0] next_irq_st = (irq_st & ~irq_clr) | ev;

   // ==================================================
   // APB slave: one wait state, registered read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= acc & ~pready;
         pslverr <= acc & ~pready & ~mapped;
         if (acc && !pready) begin
            prdata <= mapped ? rd_mux : 32'h0000_0000;
         end
      end
   end

   // Global registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `AIAW_CTRL_RST;
         rts_ms <= `AIAW_RTS_RST;
         latch_en <= 8'h00;
         alm_dis <= 8'h00;
         irq_mask <= 4'h0;
      end else if (wr_go) begin
         case (paddr)
            `AIAW_OFS_CTRL: ctrl <= {27'h000_0000, pwdata[4:0]};
            `AIAW_OFS_RTS: rts_ms <= pwdata[15:0];
            `AIAW_OFS_LATCH: latch_en <= pwdata[7:0];
            `AIAW_OFS_ALMDIS: alm_dis <= pwdata[7:0];
            `AIAW_OFS_IRQMSK: irq_mask <= pwdata[3:0];
            default: ;
         endcase
      end
   end

   // Per channel limit table
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < `AIAW_NCH; c++) begin
            for (int i = 0; i < 8; i++) begin
               cfg[c][i] <= 32'h0000_0000;
            end
         end
      end else if (wr_go && in_cfg && paddr[1:0] == 2'h0) begin
         cfg[a_ch][a_idx] <= pwdata;
      end
   end

   // Channel flags and previous sample; sample set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < `AIAW_NCH; c++) begin
            flags[c] <= 8'h00;
            prev[c] <= 32'h0000_0000;
         end
         prev_ok <= 8'h00;
      end else begin
         for (int c = 0; c < `AIAW_NCH; c++) begin
            if (samp_valid && sc == 3'(c)) begin
               flags[c] <= nf;
               prev[c] <= d;
               prev_ok[c] <= 1'b1;
            end else if (flg_clr && a_idx == 3'(c)) begin
               flags[c] <= flags[c] & ~pwdata[7:0];
            end
         end
      end
   end

   // Result stream and interrupt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         out_chan <= 3'h0;
         out_data <= 32'h0000_0000;
         out_flags <= 8'h00;
         irq_st <= 4'h0;
         irq <= 1'b0;
      end else begin
         out_valid <= samp_valid;
         if (samp_valid) begin
            out_chan <= sc;
            out_data <= d;
            out_flags <= nf;
         end
         irq_st <= next_irq_st;
         irq <= |(next_irq_st & irq_mask);
      end
   end

   // ==================================================
   // Checks
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_mode_blocks_alarm: assert property (
      samp_valid && mode_off |=> out_flags[3:0] == 4'h0)
      else $error("process alarm in disabled mode");
   a_hh_sets: assert property (
      samp_valid && alm_en && d > cfg[sc][`AIAW_C_HH]
      |=> out_flags[`AIAW_F_HH])
      else $error("high-high not set");
   a_deadband_hold: assert property (
      samp_valid && alm_en && old[`AIAW_F_H] && !clr_bits[`AIAW_F_H] &&
      d > cfg[sc][`AIAW_C_H] - db |=> out_flags[`AIAW_F_H])
      else $error("high dropped inside deadband");
   a_unlatched_clear: assert property (
      samp_valid && !lat && d >= cfg[sc][`AIAW_C_L] + db
      |=> !out_flags[`AIAW_F_L])
      else $error("low held after condition left");
   a_latch_keeps: assert property (
      samp_valid && alm_en && lat && old[`AIAW_F_LL] &&
      !clr_bits[`AIAW_F_LL] |=> out_flags[`AIAW_F_LL])
      else $error("latched low-low lost");
   a_rate_falling: assert property (
      samp_valid && alm_en && prev_ok[sc] && diff < 0 && lhs > rhs
      |=> out_flags[`AIAW_F_RATE])
      else $error("falling rate missed");
   a_rate_blocked: assert property (
      samp_valid && mode_off |=> !out_flags[`AIAW_F_RATE])
      else $error("rate alarm in disabled mode");
   a_wire_off_sub: assert property (
      samp_valid && samp_wire_off |=> out_flags[`AIAW_F_WOFF] &&
      out_data == $past(sub_val))
      else $error("wire-off not substituted");
   a_range_quiet: assert property (
      samp_valid && alm_dis[sc] |=> out_flags[6:5] == 2'h0)
      else $error("range flag with alarms disabled");
   a_odd_int_sub: assert property (
      samp_valid && samp_wire_off && ctl_int && app_diff && sc[0] &&
      rng_en |=> out_data == `AIAW_SUB_NEG1 && out_flags[`AIAW_F_BELOW])
      else $error("odd channel wire-off value");
   a_even_int_sub: assert property (
      samp_valid && samp_wire_off && ctl_int && app_diff && !sc[0] &&
      rng_en |=> out_data == `AIAW_SUB_POS1 && out_flags[`AIAW_F_ABOVE])
      else $error("even channel wire-off value");
   a_stream_follows: assert property (
      samp_valid |=> out_valid && out_chan == $past(sc) ##1 !out_valid
      || $past(samp_valid))
      else $error("result not sent next cycle");
   // High, low and low-low set on their own conditions; latched high holds
   a_h_sets: assert property (
      samp_valid && alm_en && d > cfg[sc][`AIAW_C_H]
      |=> out_flags[`AIAW_F_H])
      else $error("high not set");
   a_low_sets: assert property (
      samp_valid && alm_en && d < cfg[sc][`AIAW_C_L]
      |=> out_flags[`AIAW_F_L])
      else $error("low not set");
   a_ll_sets: assert property (
      samp_valid && alm_en && d < cfg[sc][`AIAW_C_LL]
      |=> out_flags[`AIAW_F_LL])
      else $error("low-low not set");
   a_latch_keeps_high: assert property (
      samp_valid && alm_en && lat && old[`AIAW_F_H] &&
      !clr_bits[`AIAW_F_H] |=> out_flags[`AIAW_F_H])
      else $error("latched high lost");
   // Rate in the rising direction
   a_rate_rising: assert property (
      samp_valid && alm_en && prev_ok[sc] && diff > 0 && lhs > rhs
      |=> out_flags[`AIAW_F_RATE])
      else $error("rising rate missed");
   // Substitutes for float odd/even channels and integer under/over wiring
   a_odd_float_sub: assert property (
      samp_valid && samp_wire_off && !ctl_int && app_diff && sc[0]
      |=> out_data == $past(rmin))
      else $error("odd channel float substitute");
   a_even_float_sub: assert property (
      samp_valid && samp_wire_off && !ctl_int && app_diff && !sc[0]
      |=> out_data == $past(rmax))
      else $error("even channel float substitute");
   a_under_int_sub: assert property (
      samp_valid && samp_wire_off && ctl_int && rng_en &&
      app == aiaw_pkg::AIAW_APP_UNDER |=> out_data == `AIAW_SUB_NEG0 &&
      out_flags[`AIAW_F_BELOW])
      else $error("under wiring substitute");
   a_over_int_sub: assert property (
      samp_valid && samp_wire_off && ctl_int && rng_en &&
      app == aiaw_pkg::AIAW_APP_OVER |=> out_data == `AIAW_SUB_POS0 &&
      out_flags[`AIAW_F_ABOVE])
      else $error("over wiring substitute");
   // Wire-off reaches the interrupt line
   a_irq_wire_off: assert property (
      samp_valid && samp_wire_off && irq_mask[2] |=> irq)
      else $error("wire-off interrupt missed");
endmodule
`default_nettype wire

// ### bench/aiaw_owner.sv
`default_nettype none
module aiaw_owner (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic out_valid,
   input wire logic [2:0] out_chan,
   input wire logic [31:0] out_data,
   input wire logic [7:0] out_flags,
   output logic [2:0] got_chan,
   output logic [31:0] got_data,
   output logic [7:0] got_flags,
   output int got_cnt
);
   timeunit 1ns;
   timeprecision 1ns;
   // Keeps the latest result and counts each valid result of channel data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         got_cnt <= 0;
         got_chan <= 3'h0;
         got_data <= 32'h0;
         got_flags <= 8'h00;
      end else if (out_valid) begin
         got_cnt <= got_cnt + 1;
         got_chan <= out_chan;
         got_data <= out_data;
         got_flags <= out_flags;
      end
   end
endmodule
`default_nettype wire

// ### bench/testbench.sv
`include "aiaw_consts.svh"
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
$display("[ERR] %0t mismatch %h %h", $time, (a), (b)); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, sv, wo, pready, pslverr;
   logic ov, irq, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, sd, rd, od, gd;
   logic [2:0] sc, oc, gc;
   logic [7:0] ofl, gf;
   int gn, bad_count, comparisons;
   aiaw_alarm dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .samp_valid(sv), .samp_chan(sc), .samp_data(sd),
      .samp_wire_off(wo), .out_valid(ov), .out_chan(oc), .out_data(od),
      .out_flags(ofl), .irq(irq));
   aiaw_owner own_u (.pclk(pclk), .presetn(presetn), .out_valid(ov),
      .out_chan(oc), .out_data(od), .out_flags(ofl), .got_chan(gc),
      .got_data(gd), .got_flags(gf), .got_cnt(gn));
   // ==================================================
   // Clock and bus tasks
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic conclude();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // APB transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin
         bad_count++;
         conclude();
      end
      // Answer is taken at the edge that sees pready high
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Config word i of channel c
   task automatic cw(input logic [2:0] c, input logic [2:0] i,
                     input logic [31:0] v);
      apb(1'b1, {4'h1, c, i, 2'b00}, v);
   endtask
   // One sample, waits for the owner to receive its result
   task automatic samp(input logic [2:0] c, input logic [31:0] d,
                       input logic w);
      int i, n;
      n = gn;
      @(posedge pclk);
      sv <= 1'b1;
      sc <= c;
      sd <= d;
      wo <= w;
      @(posedge pclk);
      sv <= 1'b0;
      i = 0;
      while (gn == n && i < 8) begin
         @(negedge pclk);
         i++;
      end
      if (gn == n) begin
         bad_count++;
         conclude();
      end
      `CHK(gc, c)
   endtask
   // ==================================================
   // Scenarios
   task automatic t_regs();
      apb(1'b0, `AIAW_OFS_RTS, 32'h0);
      `CHK(rd, 32'h0000_0064)
      apb(1'b0, `AIAW_OFS_CTRL, 32'h0);
      `CHK(rd, 32'h0000_0000)
      apb(1'b1, 12'h0f0, 32'hffff_ffff);
      `CHK(er, 1'b1)
      apb(1'b0, 12'h0f0, 32'h0);
      `CHK({er, rd}, {1'b1, 32'h0})
      $display("t_regs done");
   endtask
   task automatic t_proc();
      cw(3'h0, 3'h0, 32'd1000);
      cw(3'h0, 3'h1, 32'd100);
      cw(3'h0, 3'h2, -32'sd100);
      cw(3'h0, 3'h3, -32'sd200);
      cw(3'h0, 3'h4, 32'd10);
      apb(1'b0, 12'h10c, 32'h0);
      `CHK(rd, 32'hffff_ff38)
      samp(3'h0, 32'd150, 1'b0);
      `CHK(gf[3:0], 4'b0010)
      samp(3'h0, 32'd95, 1'b0);
      `CHK(gf[1], 1'b1)
      samp(3'h0, 32'd80, 1'b0);
      `CHK(gf[1], 1'b0)
      samp(3'h0, -32'sd250, 1'b0);
      `CHK(gf[3:0], 4'b1100)
      samp(3'h0, 32'd1001, 1'b0);
      `CHK(gf[3:0], 4'b0011)
      $display("t_proc done");
   endtask
   task automatic t_latch();
      apb(1'b1, `AIAW_OFS_LATCH, 32'h2);
      cw(3'h1, 3'h0, 32'd1000);
      cw(3'h1, 3'h1, 32'd100);
      cw(3'h1, 3'h2, -32'sd1000);
      cw(3'h1, 3'h3, -32'sd2000);
      samp(3'h1, 32'd200, 1'b0);
      samp(3'h1, 32'd0, 1'b0);
      `CHK(gf[1], 1'b1)
      apb(1'b0, 12'h044, 32'h0);
      `CHK(rd[1], 1'b1)
      apb(1'b1, 12'h044, 32'h2);
      samp(3'h1, 32'd0, 1'b0);
      `CHK(gf[1], 1'b0)
      apb(1'b1, `AIAW_OFS_LATCH, 32'h0);
      $display("t_latch done");
   endtask
   task automatic t_rate();
      cw(3'h4, 3'h5, 32'd1000);
      samp(3'h4, 32'd5000, 1'b0);
      samp(3'h4, 32'd5080, 1'b0);
      `CHK(gf[4], 1'b0)
      samp(3'h4, 32'd4900, 1'b0);
      `CHK(gf[4], 1'b1)
      samp(3'h4, 32'd5000, 1'b0);
      `CHK(gf[4], 1'b0)
      $display("t_rate done");
   endtask
   task automatic t_dis();
      logic [31:0] cv[3] = '{32'h1, 32'h6, 32'h2};
      logic [4:0] ex[3] = '{5'h00, 5'h00, 5'h13};
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, `AIAW_OFS_CTRL, cv[k]);
         samp(3'h4, 32'd0, 1'b0);
         samp(3'h4, 32'd9000, 1'b0);
         `CHK(gf[4:0], ex[k])
      end
      $display("t_dis done");
   endtask
   task automatic t_woff();
      logic [31:0] wc[7] = '{32'h01, 32'h01, 32'h09, 32'h11, 32'h19,
         32'h00, 32'h00};
      logic [2:0] wh[7] = '{3'h3, 3'h2, 3'h3, 3'h2, 3'h2, 3'h3, 3'h2};
      logic [31:0] wd[7] = '{32'hffff_8001, 32'h0000_7fff, 32'hffff_8001,
         32'hffff_8000, 32'h0000_8000, 32'hffff_ec78, 32'h0000_1388};
      logic [1:0] wr[7] = '{2'b01, 2'b10, 2'b01, 2'b01, 2'b10, 2'b01, 2'b10};
      for (int c = 2; c < 4; c++) begin
         cw(3'(c), 3'h6, -32'sd5000);
         cw(3'(c), 3'h7, 32'd5000);
      end
      for (int k = 0; k < 7; k++) begin
         apb(1'b1, `AIAW_OFS_CTRL, wc[k]);
         samp(wh[k], 32'h0000_0123, 1'b1);
         `CHK(gd, wd[k])
         `CHK(gf[7:5], {1'b1, wr[k]})
      end
      apb(1'b1, `AIAW_OFS_ALMDIS, 32'h4);
      apb(1'b1, `AIAW_OFS_CTRL, 32'h1);
      samp(3'h2, 32'd0, 1'b1);
      `CHK({gd, gf[7:5]}, {32'h0000_7fff, 3'b100})
      apb(1'b1, `AIAW_OFS_ALMDIS, 32'h0);
      $display("t_woff done");
   endtask
   task automatic t_irq();
      apb(1'b1, `AIAW_OFS_IRQMSK, 32'h0);
      apb(1'b1, `AIAW_OFS_IRQST, 32'hf);
      repeat (2) @(negedge pclk);
      `CHK(irq, 1'b0)
      apb(1'b1, `AIAW_OFS_IRQMSK, 32'h4);
      samp(3'h5, 32'd0, 1'b1);
      `CHK(irq, 1'b1)
      apb(1'b1, `AIAW_OFS_IRQMSK, 32'h0);
      repeat (2) @(negedge pclk);
      `CHK(irq, 1'b0)
      apb(1'b1, `AIAW_OFS_IRQMSK, 32'h4);
      apb(1'b1, `AIAW_OFS_IRQST, 32'h4);
      repeat (2) @(negedge pclk);
      `CHK(irq, 1'b0)
      apb(1'b0, `AIAW_OFS_IRQST, 32'h0);
      `CHK(rd[2], 1'b0)
      $display("t_irq done");
   endtask
   // ==================================================
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, sv, wo} = 6'h00;
      {paddr, pwdata, sd, sc} = '0;
      bad_count = 0;
      comparisons = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_proc();
      t_latch();
      t_rate();
      t_dis();
      t_woff();
      t_irq();
      conclude();
   end
endmodule
`default_nettype wire
